// ==== hdl/asq_consts.svh ====
`ifndef ASQ_CONSTS_SVH
`define ASQ_CONSTS_SVH

`define ASQ_OFF_CTRL      12'h000
`define ASQ_OFF_CMD       12'h004
`define ASQ_OFF_STATUS    12'h008
`define ASQ_OFF_COUNT     12'h00c
`define ASQ_OFF_PACE      12'h010
`define ASQ_OFF_SCANLEN   12'h014
`define ASQ_OFF_FIFO      12'h018
`define ASQ_OFF_LEVEL     12'h01c
`define ASQ_OFF_IRQ_STAT  12'h020
`define ASQ_OFF_IRQ_EN    12'h024
`define ASQ_OFF_IRQ_CLR   12'h028
`define ASQ_OFF_BLOCK     12'h02c
`define ASQ_OFF_SCAN_BASE 12'h100

`define ASQ_CTRL_HWPACE   0
`define ASQ_CTRL_EXTCLK   1
`define ASQ_CTRL_CONT     2
`define ASQ_CTRL_STARTTRG 3
`define ASQ_CTRL_REFTRG   4
`define ASQ_CTRL_BUFFERED 5
`define ASQ_CTRL_USE_DMA  6

`define ASQ_CMD_CONVERT   0
`define ASQ_CMD_ARM       1
`define ASQ_CMD_STOP      2
`define ASQ_CMD_CLR_OVR   3

`define ASQ_IRQ_DONE      0
`define ASQ_IRQ_OVR       1
`define ASQ_IRQ_BLOCK     2

`define ASQ_PACE_RESET    32'h0000_0064
`define ASQ_BLOCK_RESET   8'h08

`endif

// ==== hdl/asq_pkg.sv ====
package asq_pkg;
    typedef enum logic [1:0] {
        ASQ_TERM_DIFFERENTIAL_TERMINAL_MODE = 2'h0,
        ASQ_TERM_GRS  = 2'h1,
        ASQ_TERM_SRS  = 2'h2
    } asq_term_t;

    typedef enum logic [3:0] {
        ASQ_IDLE    = 4'b0001,
        ASQ_ARMED   = 4'b0010,
        ASQ_RUN     = 4'b0100,
        ASQ_CONVERT = 4'b1000
    } asq_state_t;
endpackage

// ==== hdl/asq_sync.sv ====
`timescale 1ns/1ps
module asq_sync (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // asq_sync

// ==== hdl/asq_fifo.sv ====
`timescale 1ns/1ps
module asq_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic                     clk_sys,
    input  wire logic                     reset,
    input  wire logic                     flush,
    input  wire logic                     wr_valid,
    output logic                          wr_ready,
    input  wire logic [WIDTH-1:0]         wr_data,
    output logic                          rd_valid,
    input  wire logic                     rd_ready,
    output logic [WIDTH-1:0]              rd_data,
    output logic [$clog2(DEPTH+1)-1:0]    level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [$clog2(DEPTH+1)-1:0] cnt_q;
    wire do_wr = wr_valid && wr_ready;
    wire do_rd = rd_valid && rd_ready;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
    end

    assign wr_ready = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign rd_valid = (cnt_q != '0);
    assign rd_data  = mem_q[rp_q];
    assign level    = cnt_q;

    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem_q[wp_q] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || flush) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) wp_q <= wp_q + 1'b1;
            if (do_rd) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (do_wr ? 1'b1 : 1'b0) - (do_rd ? 1'b1 : 1'b0);
        end
    end
endmodule // asq_fifo

// ==== hdl/asq_acq_ctrl.sv ====
`timescale 1ns/1ps
`include "asq_consts.svh"
module asq_acq_ctrl #(
    parameter int SCAN_DEPTH = 16,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_sample_clk,
    input  wire logic        start_trig,
    input  wire logic        ref_trig,
    output logic             conv_start,
    output logic [5:0]       mux_channel,
    output logic             internal_ground_sel,
    output logic [1:0]       terminal_mode,
    output logic [2:0]       gain_amplifier,
    output logic             gain_load,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_data,
    output logic             dma_req,
    output logic             irq
);
    localparam int SW = $clog2(SCAN_DEPTH);
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    initial begin
        if (SCAN_DEPTH < 2 || SCAN_DEPTH > 64) $error("SCAN_DEPTH out of range");
    end

    logic             ext_clk_s;
    logic             start_s;
    logic             ref_s;
    logic             ext_clk_p_q;
    logic             start_p_q;
    logic             ref_p_q;
    logic [6:0]       ctrl_q;
    logic [31:0]      count_q;
    logic [31:0]      pace_q;
    logic [31:0]      timer_q;
    logic [SW:0]      scanlen_q;
    logic [SW-1:0]    idx_q;
    logic [11:0]      scan_q [SCAN_DEPTH];
    logic [31:0]      done_cnt_q;
    logic [2:0]       ist_q;
    logic [2:0]       ien_q;
    logic [7:0]       block_q;
    logic             ovr_q;
    logic             cnv_pend_q;
    asq_pkg::asq_state_t state_q;
    logic [LW-1:0]    level;
    logic             f_rd_valid;
    logic [15:0]      f_rd_data;
    logic             f_wr_ready;

    asq_sync u_sync_clk (.clk_sys(clk_sys), .reset(reset), .din(ext_sample_clk), .dout(ext_clk_s));
    asq_sync u_sync_st  (.clk_sys(clk_sys), .reset(reset), .din(start_trig),     .dout(start_s));
    asq_sync u_sync_ref (.clk_sys(clk_sys), .reset(reset), .din(ref_trig),       .dout(ref_s));

    // Bus decode
    wire acc     = psel && penable;
    wire wr_en   = acc && pwrite;
    wire rd_en   = acc && !pwrite;
    wire scan_hit = paddr >= `ASQ_OFF_SCAN_BASE && paddr < 12'(`ASQ_OFF_SCAN_BASE + 4 * SCAN_DEPTH);
    wire [SW-1:0] scan_wi = paddr[SW+1:2];
    wire hit_ctrl  = paddr == `ASQ_OFF_CTRL;
    wire hit_cmd   = paddr == `ASQ_OFF_CMD;
    wire hit_stat  = paddr == `ASQ_OFF_STATUS;
    wire hit_count = paddr == `ASQ_OFF_COUNT;
    wire hit_pace  = paddr == `ASQ_OFF_PACE;
    wire hit_slen  = paddr == `ASQ_OFF_SCANLEN;
    wire hit_fifo  = paddr == `ASQ_OFF_FIFO;
    wire hit_lvl   = paddr == `ASQ_OFF_LEVEL;
    wire hit_ist   = paddr == `ASQ_OFF_IRQ_STAT;
    wire hit_ien   = paddr == `ASQ_OFF_IRQ_EN;
    wire hit_iclr  = paddr == `ASQ_OFF_IRQ_CLR;
    wire hit_blk   = paddr == `ASQ_OFF_BLOCK;
    wire mapped = hit_ctrl || hit_cmd || hit_stat || hit_count || hit_pace || hit_slen
                  || hit_fifo || hit_lvl || hit_ist || hit_ien || hit_iclr || hit_blk || scan_hit;
    wire cmd_wr  = wr_en && hit_cmd;
    wire cmd_cnv = cmd_wr && pwdata[`ASQ_CMD_CONVERT];
    wire cmd_arm = cmd_wr && pwdata[`ASQ_CMD_ARM];
    wire cmd_stp = cmd_wr && pwdata[`ASQ_CMD_STOP];
    wire cmd_clr = cmd_wr && pwdata[`ASQ_CMD_CLR_OVR];
    wire fifo_pop = rd_en && hit_fifo && f_rd_valid;

    wire hw_pace  = ctrl_q[`ASQ_CTRL_HWPACE];
    wire cont     = ctrl_q[`ASQ_CTRL_CONT];
    wire buffered = ctrl_q[`ASQ_CTRL_BUFFERED];

    // Pacing
    wire tmr_tick = timer_q == 32'h0;
    wire ext_edge = ext_clk_s && !ext_clk_p_q;
    wire hw_tick  = ctrl_q[`ASQ_CTRL_EXTCLK] ? ext_edge : tmr_tick;
    wire st_edge  = start_s && !start_p_q;
    wire rf_edge  = ref_s && !ref_p_q;
    wire running  = state_q == asq_pkg::ASQ_RUN;
    wire ref_stop = ctrl_q[`ASQ_CTRL_REFTRG] && rf_edge && !cont;
    // A convert command that lands mid-conversion waits here
    wire sw_req   = cmd_cnv || cnv_pend_q;
    // Stop and reference trigger win over a tick in the same cycle
    wire do_conv  = running && !cmd_stp && !ref_stop && (hw_pace ? hw_tick : sw_req);
    wire last_smp = !cont && (done_cnt_q + 32'h1 >= count_q);
    wire overflow = conv_done && !f_wr_ready;
    wire [11:0] ent = scan_q[idx_q];
    wire blk_ready = buffered && (32'(level) >= 32'(block_q)) && (block_q != 8'h0);

    asq_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .flush    (cmd_arm),
        .wr_valid (conv_done),
        .wr_ready (f_wr_ready),
        .wr_data  (conv_data),
        .rd_valid (f_rd_valid),
        .rd_ready (fifo_pop),
        .rd_data  (f_rd_data),
        .level    (level)
    );

    always_ff @(posedge clk_sys) begin
        if (wr_en && scan_hit) scan_q[scan_wi] <= pwdata[11:0];
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q    <= 7'h0;
            count_q   <= 32'h0;
            pace_q    <= `ASQ_PACE_RESET;
            scanlen_q <= (SW+1)'(1);
            ien_q     <= 3'h0;
            block_q   <= `ASQ_BLOCK_RESET;
        end else if (wr_en) begin
            if (hit_ctrl)  ctrl_q    <= pwdata[6:0];
            if (hit_count) count_q   <= pwdata;
            if (hit_pace)  pace_q    <= pwdata;
            if (hit_slen)  scanlen_q <= pwdata[SW:0];
            if (hit_ien)   ien_q     <= pwdata[2:0];
            if (hit_blk)   block_q   <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ext_clk_p_q <= 1'b0;
            start_p_q   <= 1'b0;
            ref_p_q     <= 1'b0;
            timer_q     <= 32'h0;
        end else begin
            ext_clk_p_q <= ext_clk_s;
            start_p_q   <= start_s;
            ref_p_q     <= ref_s;
            timer_q     <= (tmr_tick || !running) ? pace_q : timer_q - 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || hw_pace || cmd_stp || state_q == asq_pkg::ASQ_IDLE) begin
            cnv_pend_q <= 1'b0;
        end else begin
            cnv_pend_q <= sw_req && !do_conv;
        end
    end

    // Sequencer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q    <= asq_pkg::ASQ_IDLE;
            idx_q      <= '0;
            done_cnt_q <= 32'h0;
        end else if (cmd_stp || overflow) begin
            state_q <= asq_pkg::ASQ_IDLE;
        end else begin
            case (state_q)
                asq_pkg::ASQ_IDLE: begin
                    if (cmd_arm && !ovr_q) begin
                        idx_q      <= '0;
                        done_cnt_q <= 32'h0;
                        state_q    <= (hw_pace && ctrl_q[`ASQ_CTRL_STARTTRG])
                                      ? asq_pkg::ASQ_ARMED : asq_pkg::ASQ_RUN;
                    end
                end
                asq_pkg::ASQ_ARMED: begin
                    if (st_edge) state_q <= asq_pkg::ASQ_RUN;
                end
                asq_pkg::ASQ_RUN: begin
                    if (ref_stop) state_q <= asq_pkg::ASQ_IDLE;
                    else if (do_conv) state_q <= asq_pkg::ASQ_CONVERT;
                end
                asq_pkg::ASQ_CONVERT: begin
                    if (conv_done) begin
                        done_cnt_q <= done_cnt_q + 32'h1;
                        idx_q <= ((SW+1)'(idx_q) + 1'b1 >= scanlen_q) ? '0 : idx_q + 1'b1;
                        state_q <= last_smp ? asq_pkg::ASQ_IDLE : asq_pkg::ASQ_RUN;
                    end
                end
                default: state_q <= asq_pkg::ASQ_IDLE;
            endcase
        end
    end

    // Analog front-end control
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conv_start          <= 1'b0;
            gain_load           <= 1'b0;
            mux_channel         <= 6'h0;
            internal_ground_sel <= 1'b0;
            terminal_mode       <= 2'h0;
            gain_amplifier      <= 3'h0;
        end else begin
            gain_load  <= do_conv;
            conv_start <= gain_load;
            if (do_conv) begin
                mux_channel         <= ent[5:0];
                internal_ground_sel <= ent[6];
                terminal_mode       <= ent[8:7];
                gain_amplifier      <= ent[11:9];
            end
        end
    end

    // Overrun and interrupts
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ovr_q <= 1'b0;
            ist_q <= 3'h0;
        end else begin
            ovr_q <= overflow || (ovr_q && !cmd_clr);
            ist_q[`ASQ_IRQ_DONE]  <= (conv_done && last_smp && state_q == asq_pkg::ASQ_CONVERT)
                || (ist_q[`ASQ_IRQ_DONE] && !(wr_en && hit_iclr && pwdata[`ASQ_IRQ_DONE]));
            ist_q[`ASQ_IRQ_OVR]   <= overflow
                || (ist_q[`ASQ_IRQ_OVR] && !(wr_en && hit_iclr && pwdata[`ASQ_IRQ_OVR]));
            ist_q[`ASQ_IRQ_BLOCK] <= (blk_ready && !ctrl_q[`ASQ_CTRL_USE_DMA])
                || (ist_q[`ASQ_IRQ_BLOCK] && !(wr_en && hit_iclr && pwdata[`ASQ_IRQ_BLOCK]));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq     <= 1'b0;
            dma_req <= 1'b0;
        end else begin
            irq     <= |(ist_q & ien_q);
            dma_req <= blk_ready && ctrl_q[`ASQ_CTRL_USE_DMA];
        end
    end

    // Read mux
    wire [31:0] status_w = {24'h0, 2'h0, state_q != asq_pkg::ASQ_IDLE,
                            state_q == asq_pkg::ASQ_ARMED, 2'h0, ovr_q, f_rd_valid};
    wire [31:0] rd_mux =
        hit_ctrl  ? {25'h0, ctrl_q} :
        hit_stat  ? status_w :
        hit_count ? count_q :
        hit_pace  ? pace_q :
        hit_slen  ? 32'(scanlen_q) :
        hit_fifo  ? {16'h0, f_rd_data} :
        hit_lvl   ? 32'(level) :
        hit_ist   ? {29'h0, ist_q} :
        hit_ien   ? {29'h0, ien_q} :
        hit_blk   ? {24'h0, block_q} :
        scan_hit  ? {20'h0, scan_q[scan_wi]} : 32'h0;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : prdata;
        end
    end
endmodule // asq_acq_ctrl

// ==== dv/asq_acq_properties.sv ====
`timescale 1ns/1ps
module asq_acq_props (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       conv_start,
    input wire logic       gain_load,
    input wire logic [5:0] mux_channel,
    input wire logic       internal_ground_sel,
    input wire logic [1:0] terminal_mode,
    input wire logic [2:0] gain_amplifier,
    input wire logic       irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire wr = psel && pwrite;
    AST_GAIN_THEN_CONV: assert property (gain_load |=> conv_start)
        else $error("conversion did not follow gain load");
    AST_CONV_AFTER_GAIN: assert property (conv_start |-> $past(gain_load))
        else $error("conversion without gain load");
    AST_SET_HELD: assert property (conv_start |-> $stable({gain_amplifier, terminal_mode}))
        else $error("range or terminal mode moved at conversion");
    AST_CHAN_MOVE: assert property ($changed(mux_channel) |-> gain_load || $past(gain_load))
        else $error("channel changed without gain load");
    AST_GND_MOVE: assert property ($changed(internal_ground_sel) |-> gain_load || $past(gain_load))
        else $error("ground select changed without gain load");
    AST_IRQ_STICKY: assert property (irq && !wr && !$past(wr) |=> irq)
        else $error("interrupt dropped without host write");
    AST_APB_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule // asq_acq_props

bind asq_acq_ctrl asq_acq_props u_props (.*);

// ==== dv/asq_adc_model.sv ====
`timescale 1ns/1ps
module asq_adc_model #(
    parameter int LAT = 3
) (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        conv_start,
    input wire logic [11:0] setting,
    output logic            conv_done,
    output logic [15:0]     conv_data
);
    logic [11:0] cap_q;
    int          cnt_q;
    initial conv_done = 0;
    initial conv_data = 16'h0;
    // One result per start, data echoes the settings seen at start
    always @(posedge clk_sys) begin
        conv_done <= !reset && cnt_q == 1;
        conv_data <= (!reset && cnt_q == 1) ? {4'h0, cap_q} : ~conv_data;
        if (reset) begin
            cnt_q <= 0;
        end else if (conv_start) begin
            cap_q <= setting;
            cnt_q <= LAT;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule // asq_adc_model

// ==== dv/test_adc_scan_acquisition_control.sv ====
`timescale 1ns/1ps
`include "asq_consts.svh"
module test_adc_scan_acquisition_control;
    logic        clk_sys = 0;
    logic        reset   = 1;
    logic        psel    = 0;
    logic        penable = 0;
    logic        pwrite  = 0;
    logic [11:0] paddr   = 0;
    logic [31:0] pwdata  = 0;
    logic [2:0]  pins    = 0;
    logic [31:0] rdat, prdata;
    logic        rerr, pready, pslverr, conv_start, gnd, gain_load, conv_done, dma_req, irq;
    logic [5:0]  mux;
    logic [1:0]  term;
    logic [2:0]  gain;
    logic [15:0] conv_data;
    logic [11:0] seen [$];
    logic [11:0] scan [3] = '{12'h605, 12'h2c0, 12'h309};
    int          bad_count = 0;
    int          compares = 0;
    int          n = 0;
    int          k;

    initial forever #5 clk_sys = ~clk_sys;

    asq_acq_ctrl #(.SCAN_DEPTH(16), .FIFO_DEPTH(4)) uut (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_sample_clk(pins[0]),
        .start_trig(pins[1]), .ref_trig(pins[2]), .conv_start(conv_start),
        .mux_channel(mux), .internal_ground_sel(gnd), .terminal_mode(term),
        .gain_amplifier(gain), .gain_load(gain_load), .conv_done(conv_done),
        .conv_data(conv_data), .dma_req(dma_req), .irq(irq));
    asq_adc_model #(.LAT(3)) u_adc (
        .clk_sys(clk_sys), .reset(reset), .conv_start(conv_start),
        .setting({gain, term, gnd, mux}), .conv_done(conv_done),
        .conv_data(conv_data));

    always @(posedge clk_sys) begin
        if (conv_start === 1'b1) begin
            n++;
            seen.push_back({gain, term, gnd, mux});
        end
    end

    task automatic test_done;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1) begin
            chk("pready", 1, pready);
            test_done;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(0, a, 0);
        chk($sformatf("reg %h", a), e, rdat & m);
    endtask

    task automatic waitn(input int t);
        for (int i = 0; i < 300 && n < t; i++) @(posedge clk_sys);
        if (n < t) begin
            chk("conversions", t, n);
            test_done;
        end
    endtask

    task automatic pulse(input int b);
        @(posedge clk_sys);
        pins[b] <= 1;
        cyc(4);
        pins[b] <= 0;
        cyc(4);
    endtask

    initial begin
        cyc(3);
        reset <= 0;
        rdc(`ASQ_OFF_CTRL, '1, 0);
        rdc(`ASQ_OFF_PACE, '1, `ASQ_PACE_RESET);
        rdc(`ASQ_OFF_SCANLEN, '1, 1);
        rdc(`ASQ_OFF_BLOCK, '1, 32'(`ASQ_BLOCK_RESET));
        rdc(`ASQ_OFF_STATUS, '1, 0);
        apb(0, 12'h030, 32'h0);
        chk("unmapped data", 0, rdat);
        chk("unmapped error", 1, rerr);
        // Software pacing over a three-entry scan with internal ground
        for (int i = 0; i < 3; i++) wr(`ASQ_OFF_SCAN_BASE + 12'(4 * i), 32'(scan[i]));
        wr(`ASQ_OFF_SCANLEN, 3);
        wr(`ASQ_OFF_CTRL, 32'h4);
        wr(`ASQ_OFF_IRQ_EN, 32'h7);
        wr(`ASQ_OFF_CMD, 32'h2);
        cyc(20);
        chk("idle conversions", 0, n);
        for (int i = 0; i < 3; i++) begin
            wr(`ASQ_OFF_CMD, 32'h1);
            waitn(i + 1);
        end
        cyc(10);
        chk("soft conversions", 3, n);
        for (int i = 0; i < 3; i++) chk("scan entry", 32'(scan[i]), 32'(seen[i]));
        rdc(`ASQ_OFF_LEVEL, '1, 3);
        rdc(`ASQ_OFF_STATUS, 32'h1, 32'h1);
        for (int i = 0; i < 3; i++) rdc(`ASQ_OFF_FIFO, 32'hffff, 32'(scan[i]));
        wr(`ASQ_OFF_CMD, 32'h4);
        // Internal timer, finite count
        wr(`ASQ_OFF_PACE, 9);
        wr(`ASQ_OFF_COUNT, 3);
        wr(`ASQ_OFF_CTRL, 32'h1);
        k = n;
        wr(`ASQ_OFF_CMD, 32'h2);
        waitn(k + 3);
        cyc(60);
        chk("finite conversions", k + 3, n);
        chk("done irq", 1, irq);
        wr(`ASQ_OFF_IRQ_CLR, 32'h7);
        cyc(3);
        chk("irq cleared", 0, irq);
        // Continuous with nobody reading: overrun
        wr(`ASQ_OFF_CTRL, 32'h5);
        k = n;
        wr(`ASQ_OFF_CMD, 32'h2);
        waitn(k + 5);
        cyc(60);
        chk("overrun stop", k + 5, n);
        rdc(`ASQ_OFF_STATUS, 32'h2, 32'h2);
        chk("overrun irq", 1, irq);
        wr(`ASQ_OFF_CMD, 32'h2);
        cyc(40);
        chk("arm refused", k + 5, n);
        wr(`ASQ_OFF_CMD, 32'h8);
        rdc(`ASQ_OFF_STATUS, 32'h2, 32'h0);
        wr(`ASQ_OFF_IRQ_CLR, 32'h7);
        cyc(3);
        chk("irq cleared", 0, irq);
        // Continuous buffered with block requests, then stop
        wr(`ASQ_OFF_BLOCK, 2);
        wr(`ASQ_OFF_CTRL, 32'h65);
        wr(`ASQ_OFF_CMD, 32'h2);
        for (k = 0; k < 300 && dma_req !== 1'b1; k++) cyc(1);
        chk("dma request", 1, dma_req);
        if (dma_req !== 1'b1) test_done;
        wr(`ASQ_OFF_CMD, 32'h4);
        k = n;
        cyc(50);
        chk("stopped", k, n);
        apb(0, `ASQ_OFF_LEVEL, 0);
        repeat (rdat) apb(0, `ASQ_OFF_FIFO, 0);
        cyc(3);
        chk("dma released", 0, dma_req);
        // External clock, start and reference triggers
        wr(`ASQ_OFF_COUNT, 10);
        wr(`ASQ_OFF_CTRL, 32'h1b);
        k = n;
        wr(`ASQ_OFF_CMD, 32'h2);
        pulse(0);
        cyc(20);
        chk("armed wait", k, n);
        rdc(`ASQ_OFF_STATUS, 32'h10, 32'h10);
        pulse(1);
        pulse(0);
        pulse(0);
        cyc(10);
        chk("ext clock", k + 2, n);
        pulse(2);
        pulse(0);
        pulse(0);
        cyc(10);
        chk("ref stop", k + 2, n);
        test_done;
    end
endmodule // test_adc_scan_acquisition_control
